/* dtm_pkg.sv */
/*
   Constants, register map, field layout and state types of the dual 16/32-bit timer.
   Assumes a single 50 MHz system clock and an AXI4-Lite master with 8-bit byte addresses.
*/
// What this block does
// - config 0/1/4 selects 32-bit, RTC, 16-bit
// - 32-bit: A load/value words hold B high
// - 32-bit timer: A's mode field alone decides
// - 32-bit down-count, reload load value after zero
// - one-shot clears enable; periodic keeps counting
// - 32-bit zero sets A time-out flag, masked too
// - ADC trigger pulse only when trigger enabled
// - load register write reloads running counter next cycle
// - stall bit freezes counter during debug halt
// - RTC counts up, first load one, then match
// - 32.768 kHz on even pin divided to 1 Hz
// - RTC match rolls to zero, sets RTC flag
// - RTC stall override ignores both stall bits
// - 16-bit down-counter with 8-bit prescaler, own mode
// - 16-bit zero reloads load and prescale values
// - 16-bit zero sets counter time-out flag, interrupt
// - edge count: capture bit clear, event selects edges
// - each edge decrements; match sets match flag
// - match reloads, clears enable, ignores later edges
// - reset: counters and loads all ones, bus ready bits one, rest zero
package dtm_pkg;

   localparam int ADDR_W = 8;

   // ==========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_AMODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_BMODE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CTL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_IMR = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_RIS = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_MIS = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_ICR = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_AILR = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_BILR = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_AMATCH = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_BMATCH = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_APR = 8'h38;
   localparam logic [ADDR_W-1:0] OFF_BPR = 8'h3C;
   localparam logic [ADDR_W-1:0] OFF_AVAL = 8'h48;
   localparam logic [ADDR_W-1:0] OFF_BVAL = 8'h4C;

   // ==========================================================
   // field values and positions
   localparam logic [2:0] CFG_32 = 3'h0;
   localparam logic [2:0] CFG_RTC = 3'h1;
   localparam logic [2:0] CFG_16 = 3'h4;
   localparam logic [1:0] MODE_ONESHOT = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_CAPTURE = 2'h3;
   localparam int MODE_CMR = 2;
   localparam logic [1:0] EV_RISE = 2'h0;
   localparam logic [1:0] EV_FALL = 2'h1;
   localparam logic [1:0] EV_BOTH = 2'h3;
   // control bits per counter, counter B sits one stride higher
   localparam int CH_STRIDE = 8;
   localparam int CTL_EN = 0;
   localparam int CTL_STALL = 1;
   localparam int CTL_EVT = 2;
   localparam int CTL_RTC_EN = 4;
   localparam int CTL_OTE = 5;
   // flag bits per counter, same stride
   localparam int FLG_TO = 0;
   localparam int FLG_MATCH = 1;
   localparam int FLG_RTC = 3;

   // ==========================================================
   // reset values and timing
   localparam logic [15:0] CNT_RST = 16'hFFFF;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
   localparam int RTC_IN_HZ = 32768;
   localparam int RTC_TICK_HZ = 1;
   localparam int RTC_DIV_W = 15;
   localparam logic [RTC_DIV_W-1:0] RTC_DIV_LAST = RTC_DIV_W'(RTC_IN_HZ / RTC_TICK_HZ - 1);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // types
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } dtm_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dtm_axi_rsp_s;

   typedef struct packed {
      logic [2:0] cfg;
      logic [1:0][2:0] mode;
      logic [15:0] ctl;
      logic [15:0] imr;
      logic [15:0] ris;
      logic [1:0][15:0] ilr;
      logic [1:0][15:0] match;
      logic [1:0][15:0] cnt;
      logic [1:0][7:0] pr;
      logic [1:0][7:0] pre;
      logic rtc_loaded;
      logic [RTC_DIV_W-1:0] rtc_div;
      logic [1:0][2:0] sync;
      logic [1:0] lvl;
      logic adc_trig;
      logic irq;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      dtm_axi_rsp_s rsp;
   } dtm_state_s;

endpackage

/* dtm_timer.sv */
/*
   Dual 16-bit timer that also runs as one 32-bit timer or 32-bit seconds counter,
   with input edge counting, reached over AXI4-Lite.
   Assumes debug_halt is synchronous to aclk; the two capture pins are asynchronous.
*/
module dtm_timer
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire dtm_pkg::dtm_axi_req_s axi_req,
   output dtm_pkg::dtm_axi_rsp_s axi_rsp,
   // pins and system
   input wire logic [1:0] capture_compare_pin,
   input wire logic debug_halt,
   output logic adc_trigger,
   output logic timer_irq
);

   dtm_pkg::dtm_state_s s_r;
   dtm_pkg::dtm_state_s s_nxt;

   // ==========================================================
   // helpers shared by the next-state logic and the checks
   logic wr_fire;
   logic [1:0] edge_evt;
   logic rtc_tick;
   logic frz32;
   logic [31:0] c32;

   assign wr_fire = s_r.aw_got & s_r.w_got & ~s_r.rsp.bvalid;
   assign c32 = {s_r.cnt[1], s_r.cnt[0]};
   // filtered level changes once stages two and three agree
   assign edge_evt[0] = (s_r.sync[0][1] == s_r.sync[0][2]) & (s_r.sync[0][2] != s_r.lvl[0]);
   assign edge_evt[1] = (s_r.sync[1][1] == s_r.sync[1][2]) & (s_r.sync[1][2] != s_r.lvl[1]);
   assign rtc_tick = edge_evt[0] & s_r.sync[0][2] & (s_r.rtc_div == dtm_pkg::RTC_DIV_LAST);
   assign frz32 = debug_halt
      & (s_r.ctl[dtm_pkg::CTL_STALL] | s_r.ctl[dtm_pkg::CH_STRIDE + dtm_pkg::CTL_STALL])
      & ~((s_r.cfg == dtm_pkg::CFG_RTC) & s_r.ctl[dtm_pkg::CTL_RTC_EN]);

   // ==========================================================
   // register read map: bit 32 flags a hit
   function automatic logic [32:0] rd_word(dtm_pkg::dtm_state_s st, logic [7:0] a);
      logic w32;
      logic [32:0] r;
      w32 = (st.cfg != dtm_pkg::CFG_16);
      r = {1'b1, 32'h0000_0000};
      case (a)
         dtm_pkg::OFF_CFG: r[31:0] = {29'h0, st.cfg};
         dtm_pkg::OFF_AMODE: r[31:0] = {29'h0, st.mode[0]};
         dtm_pkg::OFF_BMODE: r[31:0] = {29'h0, st.mode[1]};
         dtm_pkg::OFF_CTL: r[31:0] = {16'h0, st.ctl};
         dtm_pkg::OFF_IMR: r[31:0] = {16'h0, st.imr};
         dtm_pkg::OFF_RIS: r[31:0] = {16'h0, st.ris};
         dtm_pkg::OFF_MIS: r[31:0] = {16'h0, st.ris & st.imr};
         dtm_pkg::OFF_ICR: r[31:0] = 32'h0000_0000;
         dtm_pkg::OFF_AILR: r[31:0] = {w32 ? st.ilr[1] : 16'h0, st.ilr[0]};
         dtm_pkg::OFF_BILR: r[31:0] = {16'h0, st.ilr[1]};
         dtm_pkg::OFF_AMATCH: r[31:0] = {w32 ? st.match[1] : 16'h0, st.match[0]};
         dtm_pkg::OFF_BMATCH: r[31:0] = {16'h0, st.match[1]};
         dtm_pkg::OFF_APR: r[31:0] = {24'h0, st.pr[0]};
         dtm_pkg::OFF_BPR: r[31:0] = {24'h0, st.pr[1]};
         dtm_pkg::OFF_AVAL: r[31:0] = {w32 ? st.cnt[1] : 16'h0, st.cnt[0]};
         dtm_pkg::OFF_BVAL: r[31:0] = {16'h0, st.cnt[1]};
         default: r = {1'b0, 32'h0000_0000};
      endcase
      return r;
   endfunction

   // ==========================================================
   // next state
   always_comb
   begin
      logic [15:0] set;
      logic [15:0] clr;
      logic [31:0] n32;
      logic [32:0] rd;
      logic [31:0] wd;
      logic [1:0] ev;
      logic sel;
      logic en;
      logic [31:0] mt;
      int b;
      set = 16'h0000;
      clr = 16'h0000;
      n32 = c32;
      rd = 33'h0_0000_0000;
      wd = 32'h0000_0000;
      ev = 2'h0;
      sel = 1'b0;
      en = 1'b0;
      mt = {s_r.match[1], s_r.match[0]};
      b = 0;
      s_nxt = s_r;
      s_nxt.adc_trig = 1'b0;

      // pin synchronisers and filtered levels
      for (int i = 0; i < 2; i++)
      begin
         s_nxt.sync[i] = {s_r.sync[i][1:0], capture_compare_pin[i]};
         if (edge_evt[i])
         begin
            s_nxt.lvl[i] = s_r.sync[i][2];
         end
      end

      // 32.768 kHz on the even pin divided to seconds
      if (edge_evt[0] & s_r.sync[0][2])
      begin
         s_nxt.rtc_div = (s_r.rtc_div == dtm_pkg::RTC_DIV_LAST) ? '0 : s_r.rtc_div + 1'b1;
      end

      if (s_r.cfg != dtm_pkg::CFG_16)
      begin
         // 32-bit pair, only counter A's enable and mode matter
         if (s_r.ctl[dtm_pkg::CTL_EN] & ~frz32)
         begin
            if (s_r.cfg == dtm_pkg::CFG_RTC)
            begin
               if (rtc_tick)
               begin
                  if (c32 == mt)
                  begin
                     n32 = 32'h0000_0000;
                     set[dtm_pkg::FLG_RTC] = 1'b1;
                  end
                  else
                  begin
                     n32 = c32 + 32'h0000_0001;
                  end
               end
            end
            else if (c32 == 32'h0000_0000)
            begin
               n32 = {s_r.ilr[1], s_r.ilr[0]};
               set[dtm_pkg::FLG_TO] = 1'b1;
               s_nxt.adc_trig = s_r.ctl[dtm_pkg::CTL_OTE];
               if (s_r.mode[0][1:0] == dtm_pkg::MODE_ONESHOT)
               begin
                  s_nxt.ctl[dtm_pkg::CTL_EN] = 1'b0;
               end
            end
            else
            begin
               n32 = c32 - 32'h0000_0001;
            end
         end
         s_nxt.cnt[1] = n32[31:16];
         s_nxt.cnt[0] = n32[15:0];
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            b = i * dtm_pkg::CH_STRIDE;
            en = s_r.ctl[b + dtm_pkg::CTL_EN];
            ev = s_r.ctl[b + dtm_pkg::CTL_EVT +: 2];
            sel = edge_evt[i] & (((ev == dtm_pkg::EV_RISE) & s_r.sync[i][2])
               | ((ev == dtm_pkg::EV_FALL) & ~s_r.sync[i][2]) | (ev == dtm_pkg::EV_BOTH));
            if (en & ~(debug_halt & s_r.ctl[b + dtm_pkg::CTL_STALL]))
            begin
               if (~s_r.mode[i][dtm_pkg::MODE_CMR]
                  & (s_r.mode[i][1:0] == dtm_pkg::MODE_CAPTURE))
               begin
                  // edge count, no prescaler
                  if (s_r.cnt[i] == s_r.match[i])
                  begin
                     s_nxt.cnt[i] = s_r.ilr[i];
                     s_nxt.ctl[b + dtm_pkg::CTL_EN] = 1'b0;
                     set[b + dtm_pkg::FLG_MATCH] = 1'b1;
                  end
                  else if (sel)
                  begin
                     s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
                  end
               end
               else if (s_r.mode[i][1:0] == dtm_pkg::MODE_ONESHOT
                  || s_r.mode[i][1:0] == dtm_pkg::MODE_PERIODIC)
               begin
                  if (s_r.pre[i] != 8'h00)
                  begin
                     s_nxt.pre[i] = s_r.pre[i] - 8'h01;
                  end
                  else if (s_r.cnt[i] == 16'h0000)
                  begin
                     s_nxt.cnt[i] = s_r.ilr[i];
                     s_nxt.pre[i] = s_r.pr[i];
                     set[b + dtm_pkg::FLG_TO] = 1'b1;
                     s_nxt.adc_trig = s_nxt.adc_trig | s_r.ctl[b + dtm_pkg::CTL_OTE];
                     if (s_r.mode[i][1:0] == dtm_pkg::MODE_ONESHOT)
                     begin
                        s_nxt.ctl[b + dtm_pkg::CTL_EN] = 1'b0;
                     end
                  end
                  else
                  begin
                     s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
                     s_nxt.pre[i] = s_r.pr[i];
                  end
               end
            end
         end
      end

      // ==========================================================
      // AXI4-Lite write: address and data in either order
      if (axi_req.awvalid & s_r.rsp.awready)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = axi_req.awaddr;
         s_nxt.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid & s_r.rsp.wready)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = axi_req.wdata;
         s_nxt.wstrb = axi_req.wstrb;
         s_nxt.rsp.wready = 1'b0;
      end
      if (wr_fire)
      begin
         rd = rd_word(s_r, s_r.awaddr);
         for (int k = 0; k < 4; k++)
         begin
            wd[k*8 +: 8] = s_r.wstrb[k] ? s_r.wdata[k*8 +: 8] : rd[k*8 +: 8];
         end
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.rsp.bvalid = 1'b1;
         s_nxt.rsp.bresp = rd[32] ? dtm_pkg::RESP_OKAY : dtm_pkg::RESP_SLVERR;
         case (s_r.awaddr)
            dtm_pkg::OFF_CFG:
            begin
               s_nxt.cfg = wd[2:0];
               if (wd[2:0] == dtm_pkg::CFG_RTC && !s_r.rtc_loaded)
               begin
                  s_nxt.cnt[1] = dtm_pkg::RTC_FIRST[31:16];
                  s_nxt.cnt[0] = dtm_pkg::RTC_FIRST[15:0];
                  s_nxt.rtc_loaded = 1'b1;
               end
            end
            dtm_pkg::OFF_AMODE: s_nxt.mode[0] = wd[2:0];
            dtm_pkg::OFF_BMODE: s_nxt.mode[1] = wd[2:0];
            dtm_pkg::OFF_CTL: s_nxt.ctl = wd[15:0];
            dtm_pkg::OFF_IMR: s_nxt.imr = wd[15:0];
            dtm_pkg::OFF_ICR: clr = wd[15:0];
            dtm_pkg::OFF_AILR:
            begin
               // a running counter takes the new value on the next edge
               s_nxt.ilr[0] = wd[15:0];
               s_nxt.cnt[0] = wd[15:0];
               if (s_r.cfg != dtm_pkg::CFG_16)
               begin
                  s_nxt.ilr[1] = wd[31:16];
                  s_nxt.cnt[1] = wd[31:16];
               end
            end
            dtm_pkg::OFF_BILR:
            begin
               s_nxt.ilr[1] = wd[15:0];
               s_nxt.cnt[1] = wd[15:0];
            end
            dtm_pkg::OFF_AMATCH:
            begin
               s_nxt.match[0] = wd[15:0];
               if (s_r.cfg != dtm_pkg::CFG_16)
               begin
                  s_nxt.match[1] = wd[31:16];
               end
            end
            dtm_pkg::OFF_BMATCH: s_nxt.match[1] = wd[15:0];
            dtm_pkg::OFF_APR: s_nxt.pr[0] = wd[7:0];
            dtm_pkg::OFF_BPR: s_nxt.pr[1] = wd[7:0];
            default:
            begin
               // status and counter values are read only
            end
         endcase
      end
      if (s_r.rsp.bvalid & axi_req.bready)
      begin
         s_nxt.rsp.bvalid = 1'b0;
         s_nxt.rsp.awready = 1'b1;
         s_nxt.rsp.wready = 1'b1;
      end

      // ==========================================================
      // AXI4-Lite read
      if (axi_req.arvalid & s_r.rsp.arready)
      begin
         rd = rd_word(s_r, axi_req.araddr);
         s_nxt.rsp.rdata = rd[31:0];
         s_nxt.rsp.rresp = rd[32] ? dtm_pkg::RESP_OKAY : dtm_pkg::RESP_SLVERR;
         s_nxt.rsp.rvalid = 1'b1;
         s_nxt.rsp.arready = 1'b0;
      end
      if (s_r.rsp.rvalid & axi_req.rready)
      begin
         s_nxt.rsp.rvalid = 1'b0;
         s_nxt.rsp.arready = 1'b1;
      end

      // an event in the clearing cycle survives the clear
      s_nxt.ris = (s_r.ris & ~clr) | set;
      s_nxt.irq = |(s_nxt.ris & s_nxt.imr);
   end

   // ==========================================================
   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r <= '0;
         s_r.cnt <= {dtm_pkg::CNT_RST, dtm_pkg::CNT_RST};
         s_r.ilr <= {dtm_pkg::CNT_RST, dtm_pkg::CNT_RST};
         s_r.pre <= {dtm_pkg::PRE_RST, dtm_pkg::PRE_RST};
         s_r.rsp.awready <= 1'b1;
         s_r.rsp.wready <= 1'b1;
         s_r.rsp.arready <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign axi_rsp = s_r.rsp;
   assign adc_trigger = s_r.adc_trig;
   assign timer_irq = s_r.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic run32;
   assign run32 = (s_r.cfg == dtm_pkg::CFG_32) & s_r.ctl[dtm_pkg::CTL_EN] & ~frz32 & ~wr_fire;

   a_cfg_write: assert property (wr_fire && s_r.awaddr == dtm_pkg::OFF_CFG && s_r.wstrb[0]
      |=> s_r.cfg == $past(s_r.wdata[2:0])) else $error("config not taken");
   a_load_split: assert property (wr_fire && s_r.awaddr == dtm_pkg::OFF_AILR
      && s_r.wstrb == 4'hF && s_r.cfg != dtm_pkg::CFG_16
      |=> {s_r.ilr[1], s_r.ilr[0]} == $past(s_r.wdata)) else $error("32-bit load split wrong");
   a_zero_reload: assert property (run32 && c32 == 32'h0000_0000
      |=> c32 == $past({s_r.ilr[1], s_r.ilr[0]})) else $error("32-bit reload missed");
   a_oneshot_stop: assert property (run32 && c32 == 32'h0000_0000
      && s_r.mode[0][1:0] == dtm_pkg::MODE_ONESHOT |=> !s_r.ctl[dtm_pkg::CTL_EN])
      else $error("one-shot kept running");
   a_timeout_flag: assert property (run32 && c32 == 32'h0000_0000
      |=> s_r.ris[dtm_pkg::FLG_TO] && s_r.adc_trig == $past(s_r.ctl[dtm_pkg::CTL_OTE]))
      else $error("time-out flag or trigger wrong");
   a_trig_gate: assert property (s_r.adc_trig |-> $past(s_r.ctl[dtm_pkg::CTL_OTE]
      | s_r.ctl[dtm_pkg::CH_STRIDE + dtm_pkg::CTL_OTE])) else $error("trigger while disabled");
   a_load_live: assert property (wr_fire && s_r.awaddr == dtm_pkg::OFF_BILR
      && s_r.wstrb == 4'hF |=> s_r.cnt[1] == $past(s_r.wdata[15:0]))
      else $error("load write not applied");
   a_debug_freeze: assert property (debug_halt
      && s_r.ctl[dtm_pkg::CH_STRIDE + dtm_pkg::CTL_STALL]
      && s_r.cfg == dtm_pkg::CFG_16 && !wr_fire |=> $stable(s_r.cnt[1]))
      else $error("counter moved in debug halt");
   a_rtc_roll: assert property (s_r.cfg == dtm_pkg::CFG_RTC && s_r.ctl[dtm_pkg::CTL_EN]
      && !frz32 && rtc_tick && c32 == {s_r.match[1], s_r.match[0]} && !wr_fire
      |=> c32 == 32'h0000_0000 && s_r.ris[dtm_pkg::FLG_RTC]) else $error("RTC match missed");
   a_edge_match: assert property (s_r.cfg == dtm_pkg::CFG_16 && s_r.ctl[dtm_pkg::CTL_EN]
      && !debug_halt && s_r.mode[0] == {1'b0, dtm_pkg::MODE_CAPTURE}
      && s_r.cnt[0] == s_r.match[0] && !wr_fire
      |=> !s_r.ctl[dtm_pkg::CTL_EN] && s_r.cnt[0] == $past(s_r.ilr[0])
      && s_r.ris[dtm_pkg::FLG_MATCH]) else $error("edge match not handled");
   a_flag_hold: assert property (s_r.ris[dtm_pkg::FLG_TO]
      && !(wr_fire && s_r.awaddr == dtm_pkg::OFF_ICR) |=> s_r.ris[dtm_pkg::FLG_TO])
      else $error("time-out flag lost");

   c_timeout32: cover property (run32 && c32 == 32'h0000_0000);
   c_rtc_match: cover property (s_r.ris[dtm_pkg::FLG_RTC]);
   c_edge_match: cover property (s_r.ris[dtm_pkg::FLG_MATCH]);
   c_b_timeout: cover property (s_r.ris[dtm_pkg::CH_STRIDE + dtm_pkg::FLG_TO] && timer_irq);

endmodule // dtm_timer

/* dtm_pin_model.sv */
/*
   Far-side model of the capture pin: sends a burst of level changes.
   Assumes the bench pulses start for one cycle and waits while busy is high.
*/
module dtm_pin_model
(
   // clock and control
   input wire logic aclk,
   input wire logic start,
   input wire logic [3:0] toggles,
   input wire logic [2:0] hold,
   // pin side
   output logic pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left_r;
   logic [3:0] wait_r;
   initial
   begin
      pin = 1'b0;
      left_r = 4'h0;
      wait_r = 4'h0;
   end
   // each new level stays at least four clocks, so the edge rate stays at most a quarter
   always @(posedge aclk)
      if (start)
         left_r <= toggles;
      else if (left_r != 4'h0 && wait_r == 4'h0)
      begin
         pin <= ~pin;
         left_r <= left_r - 4'h1;
         wait_r <= 4'(hold) + 4'h3;
      end
      else if (wait_r != 4'h0)
         wait_r <= wait_r - 4'h1;
   assign busy = start | (left_r != 4'h0);
endmodule // dtm_pin_model

/* dtm_timer_tb_top.sv */
/*
   Self-checking bench of the dual timer: AXI4-Lite master tasks, read monitor, pin model.
   Assumes the design answers every bus request and counts one pin edge per level change.
*/
module dtm_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, debug_halt, pm_start, pm_busy, pin_a, pin_b, adc_trigger, timer_irq;
   logic [2:0] pm_hold;
   logic [31:0] seed = 32'h0000_B8A6;
   dtm_pkg::dtm_axi_req_s req;
   dtm_pkg::dtm_axi_rsp_s rsp;
   logic [33:0] expq[$];
   int fail_count = 0;
   int checked = 0;
   int trig_n = 0;
   dtm_timer u_dtm_timer (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .capture_compare_pin({pin_b, pin_a}), .debug_halt(debug_halt),
      .adc_trigger(adc_trigger), .timer_irq(timer_irq));
   dtm_pin_model u_dtm_pin_model (.aclk(aclk), .start(pm_start), .toggles(4'h6),
      .hold(pm_hold), .pin(pin_a), .busy(pm_busy));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      cmp({32'h0000_0000, rsp.bresp}, {32'h0000_0000, dtm_pkg::RESP_OKAY});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = dtm_pkg::RESP_OKAY);
      @(posedge aclk);
      expq.push_back({r, d});
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
   endtask
   task automatic wirq(input logic e);
      int n;
      n = 0;
      while (timer_irq !== e && n < 200)
      begin
         @(posedge aclk);
         n++;
      end
      cmp({33'h0, timer_irq}, {33'h0, e});
   endtask
   // six level changes at a random pace, then time for the synchroniser
   task automatic burst();
      seed = xs(seed);
      pm_hold <= seed[2:0];
      pm_start <= 1'b1;
      @(posedge aclk);
      pm_start <= 1'b0;
      while (pm_busy === 1'b1) @(posedge aclk);
      repeat (8) @(posedge aclk);
   endtask
   // ==========================================================
   // monitor: oldest expectation against each read answer
   always @(posedge aclk)
      if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
         cmp({rsp.rresp, rsp.rdata}, expq.pop_front());
   always @(posedge aclk)
      if (adc_trigger === 1'b1) trig_n <= trig_n + 1;
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial
   begin
      #(20 * 5000);
      fail_count++;
      stop_test();
   end
   // ==========================================================
   // scenarios
   initial
   begin
      req = '0;
      debug_halt = 1'b0;
      pm_start = 1'b0;
      pm_hold = 3'h0;
      pin_b = 1'b0;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(dtm_pkg::OFF_AVAL, 32'hFFFF_FFFF);
      rd(dtm_pkg::OFF_APR, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000, dtm_pkg::RESP_SLVERR);
      $display("test reset done");
      wr(dtm_pkg::OFF_CFG, 32'h0000_0000);
      wr(dtm_pkg::OFF_AMODE, 32'h0000_0001);
      wr(dtm_pkg::OFF_BMODE, 32'h0000_0002);
      wr(dtm_pkg::OFF_AILR, 32'h0000_0030);
      rd(dtm_pkg::OFF_AVAL, 32'h0000_0030);
      wr(dtm_pkg::OFF_IMR, 32'h0000_0001);
      wr(dtm_pkg::OFF_CTL, 32'h0000_0021);
      wirq(1'b1);
      rd(dtm_pkg::OFF_RIS, 32'h0000_0001);
      rd(dtm_pkg::OFF_MIS, 32'h0000_0001);
      rd(dtm_pkg::OFF_CTL, 32'h0000_0020);
      rd(dtm_pkg::OFF_AVAL, 32'h0000_0030);
      cmp(34'(trig_n), 34'd1);
      wr(dtm_pkg::OFF_ICR, 32'h0000_0001);
      wirq(1'b0);
      rd(dtm_pkg::OFF_RIS, 32'h0000_0000);
      $display("test 32-bit one-shot done");
      wr(dtm_pkg::OFF_CFG, 32'h0000_0004);
      wr(dtm_pkg::OFF_BMODE, 32'h0000_0002);
      wr(dtm_pkg::OFF_BPR, 32'h0000_0001);
      wr(dtm_pkg::OFF_BILR, 32'h0000_0005);
      wr(dtm_pkg::OFF_IMR, 32'h0000_0100);
      debug_halt <= 1'b1;
      wr(dtm_pkg::OFF_CTL, 32'h0000_0300);
      repeat (40) @(posedge aclk);
      rd(dtm_pkg::OFF_RIS, 32'h0000_0000);
      debug_halt <= 1'b0;
      wirq(1'b1);
      rd(dtm_pkg::OFF_CTL, 32'h0000_0300);
      wr(dtm_pkg::OFF_ICR, 32'h0000_0100);
      wirq(1'b0);
      wirq(1'b1);
      cmp(34'(trig_n), 34'd1);
      $display("test 16-bit periodic done");
      wr(dtm_pkg::OFF_AMODE, 32'h0000_0003);
      wr(dtm_pkg::OFF_AILR, 32'h0000_000A);
      wr(dtm_pkg::OFF_AMATCH, 32'h0000_0006);
      wr(dtm_pkg::OFF_CTL, 32'h0000_000D);
      wr(dtm_pkg::OFF_ICR, 32'h0000_FFFF);
      burst();
      rd(dtm_pkg::OFF_RIS, 32'h0000_0002);
      rd(dtm_pkg::OFF_CTL, 32'h0000_000C);
      rd(dtm_pkg::OFF_AVAL, 32'h0000_000A);
      wr(dtm_pkg::OFF_CTL, 32'h0000_0001);
      burst();
      rd(dtm_pkg::OFF_AVAL, 32'h0000_0007);
      $display("test edge count done");
      wr(dtm_pkg::OFF_CTL, 32'h0000_0000);
      wr(dtm_pkg::OFF_CFG, 32'h0000_0001);
      rd(dtm_pkg::OFF_AVAL, 32'h0000_0001);
      $display("test seconds counter done");
      repeat (4) @(posedge aclk);
      stop_test();
   end
endmodule // dtm_timer_tb_top
